// file: core/dmapg_pkg.sv
// package: constants and types for the dma portal and global control block
// Summary of operation
// - active flag mirrors channel enable bit
// - active flag drops during descriptor fetch while the list flag is set
// - inactive data access advances selector modulo 8
// - selector above 7 toggles bit 0 only
// - selector picks subregisters 0 to 9
// - data port reaches the selected subregister
// - global pause blocks every channel request
// - clearing pause resumes channels unchanged
// - arbitration bit picks round robin/fixed
// - burst 00 runs the whole block
// - burst 01 limits grants to 4
// - burst 10 single transfer; 11 reserved
// - selector advances only with auto increment
// - upper link bit chains channels 3,2
// - lower link bit chains channels 1,0
// - list flag set on descriptor low write
// - round robin serviced channel goes last
// - fixed order ranks channel 0 highest
package dmapg_pkg;

  localparam int NCH   = 4;  // channel count
  localparam int NSUB  = 10; // subregisters per channel
  localparam int AW    = 12; // register address width

  // register addresses
  localparam logic [11:0] CH0_SEL_ADDR = 12'h0fa8;
  localparam logic [11:0] CH0_DAT_ADDR = 12'h0fa9;
  localparam logic [11:0] CH1_SEL_ADDR = 12'h0faa;
  localparam logic [11:0] CH1_DAT_ADDR = 12'h0fab;
  localparam logic [11:0] CH2_SEL_ADDR = 12'h0fac;
  localparam logic [11:0] CH2_DAT_ADDR = 12'h0fad;
  localparam logic [11:0] CH3_SEL_ADDR = 12'h0fae;
  localparam logic [11:0] CH3_DAT_ADDR = 12'h0faf;
  localparam logic [11:0] GCTL_ADDR    = 12'h0fb0;

  // select/status register fields
  localparam int SS_IRQ_BIT  = 7;
  localparam int SS_LIST_BIT = 5;
  localparam int SS_ACT_BIT  = 4;

  // subregister numbers used by this block
  localparam logic [3:0] SUB_CTL_ONE   = 4'h7;
  localparam logic [3:0] SUB_DESC_LOW  = 4'h9;
  localparam logic [3:0] SUB_LAST      = 4'h9;
  localparam logic [3:0] SUB_WRAP      = 4'h7;
  localparam int         CTL_ONE_EN_BIT = 7; // enable bit inside control one

  // global control fields
  localparam int GC_PAUSE_BIT = 7;
  localparam int GC_ARB_BIT   = 6;
  localparam int GC_BURST_LO  = 4;
  localparam int GC_RSVD_BIT  = 3;
  localparam int GC_ADV_BIT   = 2;
  localparam int GC_UPPER_BIT = 1;
  localparam int GC_LOWER_BIT = 0;
  localparam logic [7:0] GCTL_RST    = 8'h00;
  localparam logic [7:0] GCTL_WMASK  = 8'hf7;
  localparam logic [7:0] SUBREG_RST  = 8'h00;
  localparam logic [3:0] SEL_RST     = 4'h0;

  // burst field codes
  localparam logic [1:0] BURST_BLOCK  = 2'b00;
  localparam logic [1:0] BURST_FOUR   = 2'b01;
  localparam logic [1:0] BURST_SINGLE = 2'b10;
  localparam logic [1:0] FOUR_LAST    = 2'd3; // count of the fourth transfer

  // software register request carried as one bundle
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic          wr;
    logic          rd;
  } dmapg_bus_req_t;

  // global settings handed to the arbiter
  typedef struct packed {
    logic       pause;
    logic       fixed;
    logic [1:0] burst;
  } dmapg_arb_cfg_t;

endpackage : dmapg_pkg

// file: core/dmapg_arbiter.sv
// channel request arbiter with burst limits and global pause
`timescale 1ns/1ps
module dmapg_arbiter (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // settings and requests
  input  wire dmapg_pkg::dmapg_arb_cfg_t cfg,
  input  wire logic [3:0]              chan_en,
  input  wire logic [3:0]              dma_req,
  input  wire logic [3:0]              xfer_done,
  // grant
  output logic [3:0]                   chan_grant
);
  import dmapg_pkg::*;

  typedef enum logic {ARB_IDLE, ARB_BUSY} dmapg_arb_st_t;

  dmapg_arb_st_t st_r, st_nxt;
  logic [1:0] owner_r, owner_nxt; // channel holding the grant
  logic [1:0] last_r,  last_nxt;  // channel serviced most recently
  logic [1:0] cnt_r,   cnt_nxt;   // transfers in this grant
  logic [3:0] eligible;           // requests that may be served
  logic [1:0] pick;               // winner for a fresh grant
  logic       any_elig;
  logic       owner_ok;           // owner still requesting and allowed
  logic       burst_end;          // limit reached on this transfer

  // choose a channel: first requester in rotation, beginning with start itself
  function automatic logic [1:0] first_from(input logic [3:0] r, input logic [1:0] start);
    logic [1:0] res;
    logic [1:0] idx;
    res = start;
    for (int i = 3; i >= 0; i--) begin
      idx = start + i[1:0];
      if (r[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction : first_from

  // pause masks every request; enabled channels keep their state for resume
  assign eligible  = dma_req & chan_en & {4{~cfg.pause}};
  assign any_elig  = |eligible;
  assign pick      = cfg.fixed ? first_from(eligible, 2'd0)
                               : first_from(eligible, last_r + 2'd1);
  assign owner_ok  = eligible[owner_r];
  assign burst_end = (cfg.burst == BURST_SINGLE) ||
                     ((cfg.burst == BURST_FOUR) && (cnt_r == FOUR_LAST));
  assign chan_grant = (st_r == ARB_BUSY) ? (4'b0001 << owner_r) : 4'b0000;

  // grant sequencing; block mode holds while the request stays up
  always_comb begin
    st_nxt    = st_r;
    owner_nxt = owner_r;
    last_nxt  = last_r;
    cnt_nxt   = cnt_r;
    case (st_r)
      ARB_IDLE: begin
        if (any_elig) begin
          st_nxt    = ARB_BUSY;
          owner_nxt = pick;
          cnt_nxt   = 2'd0;
        end
      end
      ARB_BUSY: begin
        if (!owner_ok) begin
          st_nxt   = ARB_IDLE; // request dropped or paused
          last_nxt = owner_r;
        end else if (xfer_done[owner_r]) begin
          cnt_nxt = cnt_r + 2'd1;
          if (burst_end) begin
            st_nxt   = ARB_IDLE;
            last_nxt = owner_r;
          end
        end
      end
      default: st_nxt = ARB_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r    <= ARB_IDLE;
      owner_r <= 2'd0;
      last_r  <= 2'd3;
      cnt_r   <= 2'd0;
    end else begin
      st_r    <= st_nxt;
      owner_r <= owner_nxt;
      last_r  <= last_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

endmodule : dmapg_arbiter

// file: core/dmapg_top.sv
// register portal, status and global control of the four channel dma
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module dmapg_top (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // software register port
  input  wire dmapg_pkg::dmapg_bus_req_t  bus_req,
  output logic [7:0]                      reg_rdata,
  // channel status from the transfer engine
  input  wire logic [3:0]                 dma_req,
  input  wire logic [3:0]                 xfer_done,
  input  wire logic [3:0]                 desc_fetch,
  input  wire logic [3:0]                 list_done,
  input  wire logic [3:0]                 irq_was_mark,
  // controls to the transfer engine
  output logic [3:0]                      chan_grant,
  output logic [3:0]                      chan_active_flag,
  output logic                            upper_pair_link_bit,
  output logic                            lower_pair_link_bit,
  output logic [3:0][9:0][7:0]            subreg_out
);
  import dmapg_pkg::*;

  // channel subregister storage, ten bytes per channel
  logic [7:0] sub_r [NCH][NSUB];
  logic [3:0] subreg_selector_r [NCH]; // per channel selector
  logic [3:0] list_active_flag_r;      // linked list running
  logic [7:0] gctl_r;                  // global transfer control
  logic [7:0] rdata_r;                 // read data, one cycle late

  // decoded strobes
  logic [3:0] sel_hit;   // select/status register addressed
  logic [3:0] dat_hit;   // data port addressed
  logic       gctl_hit;
  logic [3:0] dat_acc;   // data port read or write this cycle
  logic [3:0] dat_wr;    // data port write this cycle
  logic [3:0] sel_wr;    // selector write this cycle
  logic [3:0] sel_ok;    // selector names a real subregister
  logic [3:0] chan_en;   // enable bits out of control one
  logic [7:0] rd_mux;    // read value before the output flop
  logic [7:0] ss_view [NCH];
  logic [7:0] dat_view [NCH];
  logic [3:0] sel_nxt [NCH];
  dmapg_arb_cfg_t arb_cfg;

  localparam logic [11:0] SEL_ADDR [NCH] = '{CH0_SEL_ADDR, CH1_SEL_ADDR,
                                              CH2_SEL_ADDR, CH3_SEL_ADDR};
  localparam logic [11:0] DAT_ADDR [NCH] = '{CH0_DAT_ADDR, CH1_DAT_ADDR,
                                              CH2_DAT_ADDR, CH3_DAT_ADDR};

  // selector after an inactive data access
  function automatic logic [3:0] advance(input logic [3:0] s);
    logic [3:0] r;
    r = s;
    if (s > SUB_WRAP) begin
      r = {s[3:1], ~s[0]};
    end else if (s == SUB_WRAP) begin
      r = 4'h0;
    end else begin
      r = s + 4'h1;
    end
    return r;
  endfunction : advance

  // global settings feeding the arbiter and the chain outputs
  assign gctl_hit            = bus_req.addr == GCTL_ADDR;
  assign arb_cfg.pause       = gctl_r[GC_PAUSE_BIT];
  assign arb_cfg.fixed       = gctl_r[GC_ARB_BIT];
  assign arb_cfg.burst       = gctl_r[GC_BURST_LO +: 2];
  assign upper_pair_link_bit = gctl_r[GC_UPPER_BIT];
  assign lower_pair_link_bit = gctl_r[GC_LOWER_BIT];
  assign reg_rdata           = rdata_r;

  // per channel decode, status view and selector update
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign sel_hit[c] = bus_req.addr == SEL_ADDR[c];
    assign dat_hit[c] = bus_req.addr == DAT_ADDR[c];
    assign dat_acc[c] = dat_hit[c] & (bus_req.wr | bus_req.rd);
    assign dat_wr[c]  = dat_hit[c] & bus_req.wr;
    assign sel_wr[c]  = sel_hit[c] & bus_req.wr;
    assign sel_ok[c]  = subreg_selector_r[c] <= SUB_LAST;
    assign chan_en[c] = sub_r[c][SUB_CTL_ONE][CTL_ONE_EN_BIT];
    // active mirrors enable, but drops while a list descriptor is fetched
    assign chan_active_flag[c] = chan_en[c] &
                                 ~(list_active_flag_r[c] & desc_fetch[c]);
    assign ss_view[c] = {irq_was_mark[c], 1'b0, list_active_flag_r[c],
                         chan_active_flag[c], subreg_selector_r[c]};
    // reserved selector values read as zero
    assign dat_view[c] = sel_ok[c] ? sub_r[c][subreg_selector_r[c]] : 8'h00;
    // an active channel keeps its selector on data access so transfers are not disturbed
    assign sel_nxt[c] = sel_wr[c] ? bus_req.wdata[3:0] :
                        (dat_acc[c] & ~chan_active_flag[c] & gctl_r[GC_ADV_BIT]) ?
                        advance(subreg_selector_r[c]) :
                        subreg_selector_r[c];

    for (genvar s = 0; s < NSUB; s++) begin : g_out
      assign subreg_out[c][s] = sub_r[c][s];
    end

    // selector register
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        subreg_selector_r[c] <= SEL_RST;
      end else begin
        subreg_selector_r[c] <= sel_nxt[c];
      end
    end

    // list flag: descriptor low write sets, end of list clears, set wins
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        list_active_flag_r[c] <= 1'b0;
      end else if (dat_wr[c] && subreg_selector_r[c] == SUB_DESC_LOW) begin
        list_active_flag_r[c] <= 1'b1;
      end else if (list_done[c]) begin
        list_active_flag_r[c] <= 1'b0;
      end
    end

    // subregister bytes; writes go to the byte the selector names
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        for (int s = 0; s < NSUB; s++) begin
          sub_r[c][s] <= SUBREG_RST;
        end
      end else if (dat_wr[c] && sel_ok[c]) begin
        sub_r[c][subreg_selector_r[c]] <= bus_req.wdata;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    if (gctl_hit) begin
      rd_mux = gctl_r;
    end
    for (int c = 0; c < NCH; c++) begin
      if (sel_hit[c]) begin
        rd_mux = ss_view[c];
      end
      if (dat_hit[c]) begin
        rd_mux = dat_view[c];
      end
    end
  end

  // read data flop and global control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      gctl_r  <= GCTL_RST;
    end else begin
      rdata_r <= bus_req.rd ? rd_mux : 8'h00;
      if (gctl_hit && bus_req.wr) begin
        gctl_r <= bus_req.wdata & GCTL_WMASK;
      end
    end
  end

  // arbitration among enabled channels
  dmapg_arbiter u_arb (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .cfg        (arb_cfg),
    .chan_en    (chan_en),
    .dma_req    (dma_req),
    .xfer_done  (xfer_done),
    .chan_grant (chan_grant)
  );

endmodule : dmapg_top

// file: verif/dmapg_sva.sv
// checker: port assertions of the dma portal and global control block
`timescale 1ns/1ps
module dmapg_sva (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // register port
  input wire dmapg_pkg::dmapg_bus_req_t  bus_req,
  input wire logic [7:0]                 reg_rdata,
  // channel side
  input wire logic [3:0]                 dma_req,
  input wire logic [3:0]                 desc_fetch,
  input wire logic [3:0]                 chan_grant,
  input wire logic [3:0]                 chan_active_flag,
  input wire logic                       upper_pair_link_bit,
  input wire logic                       lower_pair_link_bit,
  input wire logic [3:0][9:0][7:0]       subreg_out
);
  import dmapg_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a write taken by the global control register
  sequence gctl_wr;
    bus_req.wr && bus_req.addr == GCTL_ADDR;
  endsequence
  // a read of the global control register
  sequence gctl_rd;
    bus_req.rd && bus_req.addr == GCTL_ADDR;
  endsequence
  rdata_idle_a: assert property (!bus_req.rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  rsvd_zero_a: assert property (gctl_rd |=> !reg_rdata[GC_RSVD_BIT])
    else $error("reserved control bit not zero");
  upper_link_a: assert property (gctl_wr |=> upper_pair_link_bit == $past(bus_req.wdata[1]))
    else $error("upper link bit wrong");
  lower_link_a: assert property (gctl_wr |=> lower_pair_link_bit == $past(bus_req.wdata[0]))
    else $error("lower link bit wrong");
  active_mirror_a: assert property (!desc_fetch[1] |->
    chan_active_flag[1] == subreg_out[1][SUB_CTL_ONE][CTL_ONE_EN_BIT])
    else $error("active flag not mirroring enable");
  pause_blocks_a: assert property (gctl_wr ##0 bus_req.wdata[GC_PAUSE_BIT] |=>
    ##[1:3] chan_grant == 4'h0)
    else $error("grant kept under pause");
  grant_onehot_a: assert property ($onehot0(chan_grant))
    else $error("grant not one hot");
  grant_req_a: assert property ((chan_grant & ~$past(dma_req)) == 4'h0)
    else $error("grant without request");
endmodule : dmapg_sva

bind dmapg_top dmapg_sva chk (.ref_clk, .rst, .bus_req, .reg_rdata, .dma_req, .desc_fetch,
  .chan_grant, .chan_active_flag, .upper_pair_link_bit, .lower_pair_link_bit, .subreg_out);

// file: verif/dmapg_top_tb.sv
// testbench: register portal, status and arbiter of the dma block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t: got %h want %h", $time, a, b); end end
module dmapg_top_tb;
  import dmapg_pkg::*;
  logic                 ref_clk = 0, rst = 1, rd_seen = 0;
  dmapg_bus_req_t       bus_req = '0;
  logic [7:0]           reg_rdata, e, v;
  logic [3:0]           dma_req = 0, xfer_done = 0, desc_fetch = 0, list_done = 0;
  logic [3:0]           irq_was_mark = 0;  // kind of the last event, shown in status bit 7
  logic [3:0]           chan_grant, chan_active_flag;
  logic                 upper_pair_link_bit, lower_pair_link_bit;
  logic [3:0][9:0][7:0] subreg_out;
  logic [7:0]           q[$], d[8];
  int                   n_errors = 0, num_checks = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  dmapg_top uut (.ref_clk, .rst, .bus_req, .reg_rdata, .dma_req, .xfer_done, .desc_fetch,
    .list_done, .irq_was_mark, .chan_grant, .chan_active_flag, .upper_pair_link_bit,
    .lower_pair_link_bit, .subreg_out);
  // one bus cycle; the next call or an idle overwrites the strobes
  task automatic op(input logic w, r, input logic [11:0] a, input logic [7:0] x);
    bus_req <= '{addr: a, wdata: x, wr: w, rd: r};
    @(posedge ref_clk);
  endtask : op
  // read with the expected byte noted for the watcher
  task automatic rdx(input logic [11:0] a, input logic [7:0] x);
    q.push_back(x);
    op(0, 1, a, 8'h00);
  endtask : rdx
  // let the arbiter settle, then compare the grant away from the edge
  task automatic grant_is(input logic [3:0] x);
    bus_req <= '0;
    repeat (4) @(negedge ref_clk);
    `CHK(chan_grant, x)
    @(posedge ref_clk);
  endtask : grant_is
  // two channels request; n completions end the first grant and pass it to the other
  task automatic burst(input logic [7:0] cfg, input int n);
    logic [3:0] g;
    op(1, 0, GCTL_ADDR, cfg);
    bus_req <= '0;
    dma_req <= 4'h3;
    repeat (4) @(negedge ref_clk);
    g = 4'h1;  // channel 0 leads: nothing served yet, or channel 1 served last
    `CHK(chan_grant, g)
    @(posedge ref_clk);
    for (int i = 1; i <= n; i++) begin
      xfer_done <= g;
      @(posedge ref_clk);
      xfer_done <= 4'h0;
      repeat (3) @(negedge ref_clk);
      `CHK(chan_grant, (i < n) ? g : (g ^ 4'h3))
      @(posedge ref_clk);
    end
    dma_req <= 4'h0;
    repeat (4) @(posedge ref_clk);
  endtask : burst
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // watcher: a read taken one edge ago owes its byte now
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      e = q.pop_front();
      `CHK(reg_rdata, e)
    end
    rd_seen <= bus_req.rd && !rst;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(63));
    repeat (16) @(posedge ref_clk);
    rst <= 0;
    for (int a = 'hfa8; a <= 'hfb1; a++) rdx(12'(a), 8'h00);
    $display("test reset values done");
    for (int c = 0; c < 4; c++) begin
      op(1, 0, GCTL_ADDR, 8'h04);
      op(1, 0, CH0_SEL_ADDR + 12'(2 * c), 8'h00);
      for (int i = 0; i < 8; i++) begin
        d[i] = 8'($urandom) & 8'h7f;  // enable bit clear keeps the channel idle
        op(1, 0, CH0_DAT_ADDR + 12'(2 * c), d[i]);
      end
      rdx(CH0_SEL_ADDR + 12'(2 * c), 8'h00);
      for (int i = 0; i < 8; i++) rdx(CH0_DAT_ADDR + 12'(2 * c), d[i]);
      op(1, 0, GCTL_ADDR, 8'h00);
      op(1, 0, CH0_SEL_ADDR + 12'(2 * c), 8'h03);
      rdx(CH0_DAT_ADDR + 12'(2 * c), d[3]);
      op(1, 0, CH0_DAT_ADDR + 12'(2 * c), d[3] ^ 8'h01);
      rdx(CH0_DAT_ADDR + 12'(2 * c), d[3] ^ 8'h01);
      rdx(CH0_SEL_ADDR + 12'(2 * c), 8'h03);
    end
    $display("test selector advance done");
    op(1, 0, GCTL_ADDR, 8'h04);
    op(1, 0, CH1_SEL_ADDR, 8'h09);
    op(1, 0, CH1_DAT_ADDR, 8'h5a);
    rdx(CH1_SEL_ADDR, 8'h28);
    op(1, 0, CH1_DAT_ADDR, 8'ha5);
    rdx(CH1_SEL_ADDR, 8'h29);
    list_done <= 4'h2;
    op(0, 0, GCTL_ADDR, 8'h00);
    list_done <= 4'h0;
    rdx(CH1_SEL_ADDR, 8'h09);
    $display("test upper subregisters done");
    for (int c = 0; c < 4; c++) begin
      op(1, 0, CH0_SEL_ADDR + 12'(2 * c), 8'h07);
      op(1, 0, CH0_DAT_ADDR + 12'(2 * c), 8'h80);
      rdx(CH0_SEL_ADDR + 12'(2 * c), 8'h10);
    end
    rdx(CH3_DAT_ADDR, d[0]);
    irq_was_mark <= 4'h8;  // watermark was the last event on channel 3
    rdx(CH3_SEL_ADDR, 8'h90);
    op(1, 0, CH1_SEL_ADDR, 8'h09);
    op(1, 0, CH1_DAT_ADDR, 8'h33);
    rdx(CH1_SEL_ADDR, 8'h39);
    desc_fetch <= 4'h2;
    op(0, 0, GCTL_ADDR, 8'h00);
    `CHK(chan_active_flag, 4'hd)
    desc_fetch <= 4'h0;
    op(0, 0, GCTL_ADDR, 8'h00);
    `CHK(chan_active_flag, 4'hf)
    $display("test active status done");
    burst(8'h14, 4);
    burst(8'h24, 1);
    op(1, 0, GCTL_ADDR, 8'h44);
    dma_req <= 4'he;
    grant_is(4'h2);
    // block mode: completions never end the grant while the request stands
    repeat (5) begin
      xfer_done <= 4'h2;
      @(posedge ref_clk);
      xfer_done <= 4'h0;
      @(negedge ref_clk);
      `CHK(chan_grant, 4'h2)
      @(posedge ref_clk);
    end
    dma_req <= 4'h0;
    grant_is(4'h0);
    dma_req <= 4'hf;
    grant_is(4'h1);
    op(1, 0, GCTL_ADDR, 8'hc4);
    grant_is(4'h0);
    op(1, 0, GCTL_ADDR, 8'h44);
    grant_is(4'h1);
    dma_req <= 4'h0;
    $display("test arbitration done");
    repeat (4) begin
      v = 8'($urandom) & 8'hf7;  // software keeps the reserved bit clear
      v[5] = v[5] & ~v[4];  // burst code 11 is never programmed
      op(1, 0, GCTL_ADDR, v);
      rdx(GCTL_ADDR, v);
      `CHK({upper_pair_link_bit, lower_pair_link_bit}, v[1:0])
    end
    bus_req <= '0;
    repeat (4) @(posedge ref_clk);
    $display("test global control done");
    report_and_stop();
  end
endmodule : dmapg_top_tb
